// ==== pkg/dom_consts.svh ====
/*
 * Constants of the drive operation mode selector: register offsets, field
 * positions, reset values, setting codes and terminal function codes.
 * Assumes it is included by bare name from the design files and the bench.
 */
`ifndef DOM_CONSTS_SVH
`define DOM_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses on the APB)
`define DOM_ADDR_CFG 12'h000
`define DOM_ADDR_TERM_LO 12'h004
`define DOM_ADDR_TERM_HI 12'h008
`define DOM_ADDR_STATUS 12'h00c

// ==========================================================================
// Field positions inside the configuration word
`define DOM_CFG_MS_LSB 0
`define DOM_CFG_CS_LSB 8
`define DOM_CFG_NCS_LSB 16

// ==========================================================================
// Reset values
`define DOM_MS_RST 8'h00
`define DOM_CS_RST 8'h00
`define DOM_NCS_RST 8'h00
`define DOM_TERM_FN_RST 56'hffffffffffffff

// ==========================================================================
// Mode selection setting codes
`define DOM_MS_SWITCH 8'h00
`define DOM_MS_PANEL 8'h01
`define DOM_MS_EXTNET 8'h02
`define DOM_MS_COMB_A 8'h03
`define DOM_MS_COMB_B 8'h04
`define DOM_MS_RUNSW 8'h06
`define DOM_MS_ILOCK 8'h07

// Communication startup setting codes
`define DOM_CS_FROM_MS 8'h00
`define DOM_CS_NET 8'h01
`define DOM_CS_PU_NET 8'h0a

// Network command source: communication option
`define DOM_NCS_OPTION 8'h00

// ==========================================================================
// Input terminal function codes
`define DOM_FN_NET_PU 8'h41
`define DOM_FN_NET_EXT 8'h42
`define DOM_FN_PU_EXT 8'h10
`define DOM_FN_ILOCK 8'h0c

`endif

// ==== pkg/dom_pkg.sv ====
/*
 * Types of the drive operation mode selector.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dom_pkg;

   // ========================================================================
   // Operation mode, one-hot
   typedef enum logic [3:0] {
      DOM_PANEL = 4'h1,
      DOM_EXT = 4'h2,
      DOM_NET = 4'h4,
      DOM_COMB = 4'h8
   } dom_mode_t;

endpackage

// ==== rtl/dom_term_match.sv ====
/*
 * Finds the terminals assigned one input function and reports whether that
 * function is assigned at all and whether any terminal carrying it is on.
 * Assumes terminal levels already synchronous to clk.
 */
`timescale 1ns/1ps
`include "dom_consts.svh"

module dom_term_match
   import dom_pkg::*;
#(
   parameter logic [7:0] FN_CODE = 8'h00
) (
   // Terminal function codes, terminal 0 in the low byte
   input wire logic [55:0] term_fn,
   // Terminal levels
   input wire logic [6:0] term_in,
   // Result
   output logic fn_assigned,
   output logic fn_on
);

   // ========================================================================
   // Per terminal compare
   logic [6:0] hit;

   genvar i;
   generate
      for (i = 0; i < 7; i++) begin : g_term
         // Only a terminal coded for this function is heard
         assign hit[i] = (term_fn[8*i +: 8] == FN_CODE);
      end
   endgenerate

   // Several terminals may share one function; any of them turns it on
   assign fn_assigned = |hit;
   assign fn_on = |(hit & term_in);

endmodule

// ==== rtl/dom_mode_sel.sv ====
/*
 * Drive operation mode selector: chooses panel, network, external or combined
 * mode from the settings, option presence and the switching terminals, and
 * holds the mode in a register. Settings are written over APB.
 * Assumes: terminal, run and option inputs synchronous to clk; an APB3
 * master; the terminal function codes are held here, the power-on mode lives elsewhere.
 */
// Operation
// - Settings 0,2,7: switching inputs move into network mode only while stopped.
// - Setting 6: switching inputs change mode even while running.
// - Startup 10: net-panel input on selects panel, off selects network.
// - Net-panel input heard only on a terminal coded 65.
// - Startup 10: setting 1 panel, 2 network, 3 or 4 combined.
// - Startup 10 with setting 0 or 6 never reaches external mode.
// - Setting 7 with interlock off forces external mode.
// - Setting 7, interlock on, external mode: motor output held stopped.
// - Setting 7: switching inputs act only while interlock is on.
// - Net-external input on turns a panel choice into network.
// - Panel-external input off turns network or external into panel.
// - Setting 7, net-panel off, panel-external on: external, not network.
// - Network becomes panel when command source 0 and option absent.
// - Startup 0/1: net-external on network, off external; terminal code 66.
// - Startup 0, setting 2 never reaches panel via net-external input.
// - Net-external off with net-panel assigned lets net-panel decide.
// - Precedence: setting, interlock, net-external, net-panel, panel-external, startup.
// - Settings 0,6,7: panel-external on selects external, off panel.
`timescale 1ns/1ps
`include "dom_consts.svh"

module dom_mode_sel
   import dom_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive state
   input wire logic [6:0] term_in,
   input wire logic motor_running,
   input wire logic start_cmd,
   input wire logic option_present,
   // Result
   output logic [3:0] mode,
   output logic output_stop
);

   // ========================================================================
   // Registers
   logic [7:0] ms_q;
   logic [7:0] cs_q;
   logic [7:0] ncs_q;
   logic [55:0] term_fn_q;
   dom_mode_t mode_q;
   dom_mode_t mode_d;
   logic stop_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // ========================================================================
   // Terminal functions
   logic net_pu_asg;
   logic net_pu_on;
   logic net_ext_asg;
   logic net_ext_on;
   logic pu_ext_asg;
   logic pu_ext_on;
   logic ilock_on;

   // Net-panel switching input
   dom_term_match #(.FN_CODE(`DOM_FN_NET_PU)) u_net_pu (
      .term_fn(term_fn_q),
      .term_in(term_in),
      .fn_assigned(net_pu_asg),
      .fn_on(net_pu_on)
   );

   // Net-external switching input
   dom_term_match #(.FN_CODE(`DOM_FN_NET_EXT)) u_net_ext (
      .term_fn(term_fn_q),
      .term_in(term_in),
      .fn_assigned(net_ext_asg),
      .fn_on(net_ext_on)
   );

   // Panel-external switching input
   dom_term_match #(.FN_CODE(`DOM_FN_PU_EXT)) u_pu_ext (
      .term_fn(term_fn_q),
      .term_in(term_in),
      .fn_assigned(pu_ext_asg),
      .fn_on(pu_ext_on)
   );

   // Panel interlock; an unassigned interlock reads as off
   dom_term_match #(.FN_CODE(`DOM_FN_ILOCK)) u_ilock (
      .term_fn(term_fn_q),
      .term_in(term_in),
      .fn_assigned(),
      .fn_on(ilock_on)
   );

   // ========================================================================
   // Setting decode
   wire ms_sw = (ms_q == `DOM_MS_SWITCH);
   wire ms_panel = (ms_q == `DOM_MS_PANEL);
   wire ms_extnet = (ms_q == `DOM_MS_EXTNET);
   wire ms_comb = (ms_q == `DOM_MS_COMB_A) || (ms_q == `DOM_MS_COMB_B);
   wire ms_runsw = (ms_q == `DOM_MS_RUNSW);
   wire ms_ilock = (ms_q == `DOM_MS_ILOCK);
   wire ms_switchable = ms_sw || ms_runsw || ms_ilock;
   wire cs_pu_net = (cs_q == `DOM_CS_PU_NET);
   wire cs_ext_net = (cs_q == `DOM_CS_FROM_MS) || (cs_q == `DOM_CS_NET);
   wire no_option = (ncs_q == `DOM_NCS_OPTION) && !option_present;

   // ========================================================================
   // Target mode, strongest cause first
   // Interlocked setting with interlock off wins over every terminal
   wire forced_ext = ms_ilock && !ilock_on;

   // Network side of the net-panel input: panel-external may pull it away
   dom_mode_t net_side;
   assign net_side = (pu_ext_asg && !pu_ext_on) ? DOM_PANEL :
                     (ms_ilock && pu_ext_on) ? DOM_EXT :
                     DOM_NET;

   // Net-panel input; net-external on overrides a panel choice
   dom_mode_t pu_net_sel;
   assign pu_net_sel = net_pu_on ? (net_ext_on ? DOM_NET : DOM_PANEL) :
                       net_side;

   // Startup 10 never moves settings 0 and 6 into external; it only keeps it
   dom_mode_t cs10_sel;
   assign cs10_sel = ms_extnet ? DOM_NET :
                     net_pu_asg ? pu_net_sel :
                     (ms_ilock && pu_ext_asg && pu_ext_on) ? DOM_EXT :
                     mode_q;

   // Panel-external alone: on external, off panel
   dom_mode_t pu_ext_sel;
   assign pu_ext_sel = pu_ext_on ? DOM_EXT : DOM_PANEL;

   // Startup 0 or 1: net-external decides, then net-panel, then panel-external
   dom_mode_t cs01_sel;
   assign cs01_sel = ms_extnet ? (net_ext_on ? DOM_NET : DOM_EXT) :
                     net_ext_on ? DOM_NET :
                     net_pu_asg ? pu_net_sel :
                     pu_ext_asg ? pu_ext_sel :
                     (net_ext_asg ? DOM_EXT : mode_q);

   // Fixed settings, then startup choice; unknown codes keep the mode
   dom_mode_t raw_sel;
   assign raw_sel = ms_panel ? DOM_PANEL :
                    ms_comb ? DOM_COMB :
                    forced_ext ? DOM_EXT :
                    !(ms_switchable || ms_extnet) ? mode_q :
                    cs_pu_net ? cs10_sel :
                    cs_ext_net ? cs01_sel :
                    mode_q;

   // No network without a command source to drive it
   dom_mode_t tgt;
   assign tgt = (raw_sel == DOM_NET && no_option) ? DOM_PANEL : raw_sel;

   // ========================================================================
   // Change permission
   // Stopped means motor stopped or start command off
   wire stopped = !motor_running || !start_cmd;
   // Interlocked setting hears the terminals only with interlock on
   wire ilock_ok = !ms_ilock || ilock_on;
   // Run-time switching lets a change through while running
   wire permit = (stopped || ms_runsw) && ilock_ok;
   // The forced external change does not wait for a stop
   wire take = (tgt != mode_q) && (forced_ext || permit);

   // Next mode; a non one-hot target falls back to external
   always_comb begin
      mode_d = mode_q;
      if (take) begin
         case (tgt)
            DOM_PANEL, DOM_EXT, DOM_NET, DOM_COMB: begin
               mode_d = tgt;
            end
            default: begin
               mode_d = DOM_EXT;
            end
         endcase
      end
   end

   // Mode register; reset picks external until the power-on logic says more
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q <= DOM_EXT;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Output stop follows the mode it is going into, so it never lags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stop_q <= 1'b0;
      end else begin
         stop_q <= ms_ilock && ilock_on && (mode_d == DOM_EXT);
      end
   end

   // ========================================================================
   // APB slave: answers in the first access cycle
   wire setup = psel && !penable;
   wire wr_en = psel && penable && pready_q && pwrite;
   wire hit_cfg = (paddr == `DOM_ADDR_CFG);
   wire hit_lo = (paddr == `DOM_ADDR_TERM_LO);
   wire hit_hi = (paddr == `DOM_ADDR_TERM_HI);
   wire hit_st = (paddr == `DOM_ADDR_STATUS);
   wire hit_any = hit_cfg || hit_lo || hit_hi || hit_st;

   // Read mux; unused bits read as zero
   wire [31:0] cfg_word = {8'h00, ncs_q, cs_q, ms_q};
   wire [31:0] st_word = {22'h000000, ilock_on, pu_ext_on, net_ext_on, net_pu_on, permit, stop_q, mode_q};
   wire [31:0] rd_word = hit_cfg ? cfg_word :
                         hit_lo ? term_fn_q[31:0] :
                         hit_hi ? {8'h00, term_fn_q[55:32]} :
                         hit_st ? st_word :
                         32'h00000000;

   // Handshake flops; status writes are ignored without error
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !hit_any;
         prdata_q <= (setup && !pwrite) ? rd_word : 32'h00000000;
      end
   end

   // Setting registers, written at the completing edge only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ms_q <= `DOM_MS_RST;
         cs_q <= `DOM_CS_RST;
         ncs_q <= `DOM_NCS_RST;
         term_fn_q <= `DOM_TERM_FN_RST;
      end else if (wr_en) begin
         if (hit_cfg) begin
            ms_q <= pwdata[`DOM_CFG_MS_LSB +: 8];
            cs_q <= pwdata[`DOM_CFG_CS_LSB +: 8];
            ncs_q <= pwdata[`DOM_CFG_NCS_LSB +: 8];
         end
         if (hit_lo) begin
            term_fn_q[31:0] <= pwdata;
         end
         if (hit_hi) begin
            term_fn_q[55:32] <= pwdata[23:0];
         end
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign mode = mode_q;
   assign output_stop = stop_q;

   // ========================================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Running without run-time switching, only the forced change goes through
   AST_RUN_HOLD: assert property (
      (motor_running && start_cmd && !ms_runsw && !forced_ext) |=> $stable(mode_q))
      else $error("mode changed while running");

   // Run-time switching follows the target even while running
   AST_RUNSW_FOLLOW: assert property (
      (ms_runsw && motor_running && start_cmd) ##1 ($stable(tgt) && $stable(ms_q)) [*2]
      |-> mode_q == tgt)
      else $error("run-time switching did not follow target");

   // Startup 10 with net-panel on and net-external off chooses panel
   AST_CS10_PANEL: assert property (
      (cs_pu_net && ms_sw && net_pu_on && !net_ext_on) |-> tgt == DOM_PANEL)
      else $error("net-panel on did not select panel");

   // Startup 10, setting 2 is fixed network
   AST_CS10_FIXED_NET: assert property (
      (cs_pu_net && ms_extnet && !no_option) |-> tgt == DOM_NET)
      else $error("fixed network not selected");

   // Startup 10 with setting 0 or 6 targets external only when already external
   AST_CS10_NO_EXT: assert property (
      (cs_pu_net && (ms_sw || ms_runsw)) |-> (tgt != DOM_EXT || mode_q == DOM_EXT))
      else $error("external reached under startup 10");

   // Interlock off on setting 7 lands in external on the next edge
   AST_FORCED_EXT: assert property (
      forced_ext |=> mode_q == DOM_EXT)
      else $error("interlock off did not force external");

   // Interlocked external mode holds the motor output stopped
   AST_ILOCK_STOP: assert property (
      (ms_ilock && ilock_on && mode_q == DOM_EXT) [*2] |-> output_stop)
      else $error("output stop missing in interlocked external");

   // No network target without a command source
   AST_NO_SOURCE: assert property (
      no_option |-> tgt != DOM_NET)
      else $error("network chosen without command source");

   // Startup 0, setting 2 never targets panel
   AST_CS0_NO_PANEL: assert property (
      (cs_q == `DOM_CS_FROM_MS && ms_extnet && !no_option) |-> tgt != DOM_PANEL)
      else $error("panel reached under setting 2");

   // Startup 0/1 with net-external on goes to network once stopped
   AST_NET_EXT_ON: assert property (
      (cs_ext_net && ms_sw && net_ext_on && !no_option && stopped) |=> mode_q == DOM_NET)
      else $error("net-external on did not select network");

   // Fixed panel setting lands in panel once stopped
   AST_PANEL_FIXED: assert property (
      (ms_panel && stopped) |=> mode_q == DOM_PANEL)
      else $error("fixed panel not selected");

   // Net-external on turns the net-panel panel choice into network
   AST_CS10_NET_EXT: assert property (
      (cs_pu_net && ms_sw && net_pu_on && net_ext_on && !no_option) |-> tgt == DOM_NET)
      else $error("net-external on did not override panel");

   // Panel-external alone on startup 0/1 selects external once stopped
   AST_PU_EXT_ON: assert property (
      (cs_ext_net && ms_sw && !net_ext_on && !net_pu_asg && pu_ext_on && stopped) |=> mode_q == DOM_EXT)
      else $error("panel-external on did not select external");

endmodule

// ==== sim/dom_term_model.sv ====
/*
 * Partner model of the digital input terminals that feed the mode selector.
 * Assumes the bench assigns codes 65, 66, 16 and 12 to terminals 0 to 3;
 * terminals 4 to 6 stay unassigned.
 */
`timescale 1ns/1ps

module dom_term_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Switch levels requested by the bench
   input wire logic net_pu_on,
   input wire logic net_ext_on,
   input wire logic pu_ext_on,
   input wire logic ilock_on,
   // Terminal levels
   output logic [6:0] term_in
);
   // ======================================================================
   // Terminal drive
   // Spare terminals toggle every cycle, so a selector that wrongly listens
   // to an unassigned terminal sees no steady level to lean on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         term_in <= 7'h50;
      end else begin
         term_in <= {~term_in[6:4], ilock_on, pu_ext_on, net_ext_on, net_pu_on};
      end
   end
endmodule

// ==== sim/dom_mode_sel_tb.sv ====
/*
 * Self-checking bench of the drive operation mode selector.
 * Assumes the APB slave answers by itself and the terminal model in front.
 */
`timescale 1ns/1ps
`include "dom_consts.svh"

module dom_mode_sel_tb
   import dom_pkg::*;
;
   // ======================================================================
   // Signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [6:0] term_in;
   logic motor_running = 1'b0;
   logic start_cmd = 1'b0;
   logic option_present = 1'b1;
   logic [3:0] mode;
   logic output_stop;
   logic np = 1'b0;
   logic ne = 1'b0;
   logic pe = 1'b0;
   logic il = 1'b0;
   int fails = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic err;
   dom_mode_t tbl [4] = '{DOM_PANEL, DOM_NET, DOM_COMB, DOM_COMB};

   // 250 MHz clock
   always #2 clk = ~clk;

   dom_mode_sel u_dom_mode_sel (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .term_in(term_in), .motor_running(motor_running), .start_cmd(start_cmd),
      .option_present(option_present), .mode(mode), .output_stop(output_stop));

   dom_term_model u_dom_term_model (.clk(clk), .rst(rst), .net_pu_on(np), .net_ext_on(ne),
      .pu_ext_on(pe), .ilock_on(il), .term_in(term_in));

   // ======================================================================
   // Checking and closing
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ======================================================================
   // APB master: hold the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Set switch levels, let model and selector register them, then compare
   task automatic sw(input logic a, input logic b, input logic c, input logic d, input dom_mode_t m);
      np <= a;
      ne <= b;
      pe <= c;
      il <= d;
      repeat (4) @(posedge clk);
      chk("mode", {28'h0, m}, {28'h0, mode});
   endtask

   initial begin
      #40000;
      fails++;
      results();
   end

   // ======================================================================
   // Tests
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `DOM_ADDR_CFG, 32'h0);
      chk("cfg", 32'h0, rd);
      apb(1'b0, `DOM_ADDR_TERM_LO, 32'h0);
      chk("term_lo", 32'hffffffff, rd);
      apb(1'b0, `DOM_ADDR_TERM_HI, 32'h0);
      chk("term_hi", 32'h00ffffff, rd);
      apb(1'b1, `DOM_ADDR_STATUS, 32'h1f);
      apb(1'b0, `DOM_ADDR_STATUS, 32'h0);
      chk("status", 32'h2, {27'h0, rd[4:0]});
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      chk("unmapped_data", 32'h0, rd);
      $display("test registers done");
      // Net-external switching, no net-panel terminal
      apb(1'b1, `DOM_ADDR_TERM_LO, 32'h0c1042ff);
      sw(1'b0, 1'b1, 1'b1, 1'b0, DOM_NET);
      sw(1'b1, 1'b0, 1'b1, 1'b0, DOM_EXT);
      sw(1'b0, 1'b0, 1'b0, 1'b0, DOM_PANEL);
      option_present <= 1'b0;
      sw(1'b0, 1'b1, 1'b1, 1'b0, DOM_PANEL);
      option_present <= 1'b1;
      sw(1'b0, 1'b1, 1'b1, 1'b0, DOM_NET);
      $display("test net_ext done");
      // Running: only setting 6 may switch
      motor_running <= 1'b1;
      start_cmd <= 1'b1;
      sw(1'b0, 1'b0, 1'b1, 1'b0, DOM_NET);
      apb(1'b1, `DOM_ADDR_CFG, 32'h6);
      sw(1'b0, 1'b0, 1'b1, 1'b0, DOM_EXT);
      sw(1'b0, 1'b1, 1'b1, 1'b0, DOM_NET);
      motor_running <= 1'b0;
      start_cmd <= 1'b0;
      $display("test running done");
      // Interlocked setting, then setting 2
      apb(1'b1, `DOM_ADDR_CFG, 32'h7);
      sw(1'b0, 1'b1, 1'b1, 1'b0, DOM_EXT);
      chk("output_stop", 32'h0, {31'h0, output_stop});
      sw(1'b0, 1'b1, 1'b1, 1'b1, DOM_NET);
      sw(1'b0, 1'b0, 1'b1, 1'b1, DOM_EXT);
      chk("output_stop", 32'h1, {31'h0, output_stop});
      apb(1'b1, `DOM_ADDR_CFG, 32'h2);
      sw(1'b0, 1'b1, 1'b0, 1'b0, DOM_NET);
      sw(1'b0, 1'b0, 1'b0, 1'b0, DOM_EXT);
      $display("test interlock done");
      // Net-panel switching with startup 10, then with startup 0
      apb(1'b1, `DOM_ADDR_TERM_LO, 32'h0c104241);
      apb(1'b1, `DOM_ADDR_CFG, 32'h00000a00);
      sw(1'b1, 1'b0, 1'b1, 1'b0, DOM_PANEL);
      sw(1'b0, 1'b0, 1'b1, 1'b0, DOM_NET);
      sw(1'b1, 1'b1, 1'b1, 1'b0, DOM_NET);
      sw(1'b1, 1'b0, 1'b1, 1'b0, DOM_PANEL);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `DOM_ADDR_CFG, 32'h00000a01 + i);
         sw(1'b1, 1'b0, 1'b1, 1'b0, tbl[i]);
      end
      apb(1'b1, `DOM_ADDR_CFG, 32'h00000a07);
      sw(1'b1, 1'b0, 1'b1, 1'b1, DOM_PANEL);
      sw(1'b0, 1'b0, 1'b1, 1'b1, DOM_EXT);
      chk("output_stop", 32'h1, {31'h0, output_stop});
      apb(1'b1, `DOM_ADDR_CFG, 32'h0);
      sw(1'b1, 1'b0, 1'b1, 1'b0, DOM_PANEL);
      sw(1'b0, 1'b0, 1'b1, 1'b0, DOM_NET);
      $display("test net_pu done");
      results();
   end
endmodule
